/* File: design/ras_params.svh */
// Constants of the return address stack: offsets, field positions, reset values and vectors.
// Assumes inclusion by bare name from the design and bench files.
`ifndef RAS_PARAMS_SVH
`define RAS_PARAMS_SVH
// ----------------------------------------
// Register byte offsets on the APB
// ----------------------------------------
`define RAS_OFF_PTR      8'h00
`define RAS_OFF_TOP_U    8'h04
`define RAS_OFF_TOP_H    8'h08
`define RAS_OFF_TOP_L    8'h0c
// ----------------------------------------
// Pointer register fields and reset values
// ----------------------------------------
`define RAS_FULL_BIT     7
`define RAS_UNDER_BIT    6
`define RAS_PTR_RST      5'h00
`define RAS_PTR_LAST     5'h1f
`define RAS_PTR_PREFULL  5'h1e
`define RAS_PC_RST       21'h000000
// ----------------------------------------
// Program counter vectors and step
// ----------------------------------------
`define RAS_VEC_RESET    21'h000000
`define RAS_VEC_HIGH     21'h000008
`define RAS_VEC_LOW      21'h000018
`define RAS_PC_STEP      21'h000002
`endif

/* File: design/ras_pkg.sv */
// Types shared by the return address stack modules.
// Assumes nothing of its surroundings.
package ras_pkg;
  // Request from the instruction sequencer, one cycle per operation
  typedef struct packed {
    logic        call_push;  // Absolute or relative call
    logic        irq_push;   // Interrupt acknowledged
    logic        irq_high;   // Acknowledged interrupt is high priority
    logic        wake_irq;   // Interrupt wake-up from sleep
    logic        gie_high;   // global_enable_high_priority
    logic        gie_low;    // global_enable_low_priority
    logic        ret_pop;    // Return, return_with_literal or return_from_interrupt
    logic        push_inst;  // Push instruction
    logic        pop_inst;   // Pop instruction
    logic [20:0] pc;         // Current program counter
  } ras_seq_req_t;

  // Pointer register image
  typedef struct packed {
    logic       stack_full_flag;
    logic       stack_underflow_flag;
    logic       zero;
    logic [4:0] ptr;
  } ras_ptr_reg_t;
endpackage : ras_pkg

/* File: design/ras_entry.sv */
// One 21-bit stack entry with per-byte write enables.
// Assumes a single synchronous clock and an asynchronous high reset.
`timescale 1ns/10ps
module ras_entry #(
  parameter int W = 21
) (
  input  wire logic         ref_clk_i,
  input  wire logic         rst_i,
  input  wire logic [2:0]   we_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      q_o <= '0;
    end
    else
    begin
      for (int b = 0; b < 3; b++)
      begin
        for (int k = 0; k < 8; k++)
        begin
          if (we_i[b] && (b * 8 + k) < W)
          begin
            q_o[b * 8 + k] <= d_i[b * 8 + k];
          end
        end
      end
    end
  end
endmodule : ras_entry

/* File: design/ras_apb_slave.sv */
// APB slave front end: zero-wait answer, registered read data and error.
// Assumes the owner supplies read data and a hit flag decoded from paddr_i.
`timescale 1ns/10ps
module ras_apb_slave (
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [31:0] rd_data_i,
  input  wire logic        hit_i,
  output logic             pready_o,
  output logic             pslverr_o,
  output logic      [31:0] prdata_o,
  output logic             wr_stb_o
);
  logic setup;

  assign setup    = psel_i && !penable_i;
  // Write commits only at the completing edge
  assign wr_stb_o = psel_i && penable_i && pready_o && pwrite_i && hit_i;

  // Read data is captured at the setup edge; one access cycle follows
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h00000000;
    end
    else
    begin
      pready_o  <= setup;
      pslverr_o <= setup && !hit_i;
      prdata_o  <= (setup && !pwrite_i && hit_i) ? rd_data_i : 32'h00000000;
    end
  end
endmodule : ras_apb_slave

/* File: design/ras_top.sv */
// Return address stack of the core: 31 x 21-bit entries, pointer, flags and APB registers.
// Assumes the sequencer raises at most one operation per cycle, synchronous to ref_clk_i.
`timescale 1ns/10ps
`include "ras_params.svh"
module ras_top #(
  parameter int DEPTH      = 31,
  parameter int IMPL_BYTES = 32768
) (
  input  wire logic                 ref_clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 core_reset_i,
  input  wire logic                 fault_reset_enable_i,
  input  wire ras_pkg::ras_seq_req_t seq_req_i,
  input  wire logic [20:0]          fetch_addr_i,
  input  wire logic [15:0]          fetch_word_i,
  input  wire logic                 psel_i,
  input  wire logic                 penable_i,
  input  wire logic                 pwrite_i,
  input  wire logic [7:0]           paddr_i,
  input  wire logic [31:0]          pwdata_i,
  output logic      [31:0]          prdata_o,
  output logic                      pready_o,
  output logic                      pslverr_o,
  output logic                      pc_load_valid_o,
  output logic      [20:0]          pc_load_o,
  output logic                      stack_reset_o,
  output logic      [15:0]          fetch_word_o
);
  localparam logic [21:0] IMPL_LIM = 22'(IMPL_BYTES);

  logic [4:0]  ptr;
  logic        full_flag;
  logic        under_flag;
  logic [20:0] ent_q [0:DEPTH];
  logic [20:0] top;
  logic        push_any;
  logic        pop_any;
  logic        wake_ok;
  logic [4:0]  next_ptr;
  logic        hw_we;
  logic [20:0] hw_data;
  logic        set_full;
  logic        set_under;
  logic        fault;
  logic        wr_stb;
  logic        hit;
  logic [31:0] rd_data;
  logic        sw_ptr_wr;
  logic [2:0]  sw_lane;
  ras_pkg::ras_ptr_reg_t ptr_img;

  // ----------------------------------------
  // Stack storage
  // ----------------------------------------
  // Index zero is no storage, only the empty mark
  assign ent_q[0] = `RAS_PC_RST;
  for (genvar i = 1; i <= DEPTH; i++)
  begin : g_ent
    logic [2:0] we;
    assign we = (hw_we && next_ptr_tgt(ptr) == 5'(i)) ? 3'h7 :
                (!hw_we && ptr == 5'(i)) ? sw_lane : 3'h0;
    ras_entry #(.W(21)) u_ent (
      .ref_clk_i (ref_clk_i),
      .rst_i     (rst_i),
      .we_i      (we),
      .d_i       (hw_we ? hw_data : {pwdata_i[4:0], pwdata_i[7:0], pwdata_i[7:0]}),
      .q_o       (ent_q[i])
    );
  end

  function automatic logic [4:0] next_ptr_tgt(input logic [4:0] p);
    next_ptr_tgt = 5'(p + 5'h01);
  endfunction : next_ptr_tgt

  assign top = ent_q[ptr];

  // ----------------------------------------
  // Operation decode
  // ----------------------------------------
  assign wake_ok  = seq_req_i.wake_irq && (seq_req_i.gie_high || seq_req_i.gie_low);
  assign push_any = seq_req_i.call_push || seq_req_i.irq_push || wake_ok || seq_req_i.push_inst;
  assign pop_any  = seq_req_i.ret_pop || seq_req_i.pop_inst;

  // Hardware operations win over a software pointer write in the same cycle
  always_comb
  begin
    next_ptr  = ptr;
    hw_we     = 1'b0;
    hw_data   = seq_req_i.pc;
    set_full  = 1'b0;
    set_under = 1'b0;
    fault     = 1'b0;
    if (core_reset_i)
    begin
      next_ptr = `RAS_PTR_RST;
    end
    else if (push_any)
    begin
      if (ptr == `RAS_PTR_LAST)
      begin
        set_full = 1'b1;
      end
      else
      begin
        hw_we    = 1'b1;
        next_ptr = 5'(ptr + 5'h01);
        if (ptr == `RAS_PTR_PREFULL)
        begin
          set_full = 1'b1;
          if (fault_reset_enable_i)
          begin
            hw_data  = 21'(seq_req_i.pc + `RAS_PC_STEP);
            next_ptr = `RAS_PTR_RST;
            fault    = 1'b1;
          end
        end
      end
    end
    else if (pop_any)
    begin
      if (ptr == `RAS_PTR_RST)
      begin
        set_under = 1'b1;
        fault     = fault_reset_enable_i;
      end
      else
      begin
        next_ptr = 5'(ptr - 5'h01);
      end
    end
    else if (sw_ptr_wr)
    begin
      next_ptr = pwdata_i[4:0];
    end
  end

  // ----------------------------------------
  // Pointer and flags
  // ----------------------------------------
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ptr <= `RAS_PTR_RST;
    end
    else
    begin
      ptr <= next_ptr;
    end
  end

  // Power-on reset or a software pointer write with the bit low clears a flag, core reset does not; set wins over a software clear
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      full_flag  <= 1'b0;
      under_flag <= 1'b0;
    end
    else
    begin
      if (sw_ptr_wr && !pwdata_i[`RAS_FULL_BIT])
      begin
        full_flag <= 1'b0;
      end
      if (sw_ptr_wr && !pwdata_i[`RAS_UNDER_BIT])
      begin
        under_flag <= 1'b0;
      end
      if (set_full)
      begin
        full_flag <= 1'b1;
      end
      if (set_under)
      begin
        under_flag <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Program counter load and fault reset
  // ----------------------------------------
  // Latch registers of the PC are outside this block and never driven here
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pc_load_valid_o <= 1'b0;
      pc_load_o       <= `RAS_PC_RST;
      stack_reset_o   <= 1'b0;
    end
    else
    begin
      pc_load_valid_o <= 1'b0;
      stack_reset_o   <= fault;
      if (core_reset_i)
      begin
        pc_load_o <= `RAS_PC_RST;
      end
      else if (push_any && (seq_req_i.irq_push || wake_ok))
      begin
        pc_load_valid_o <= 1'b1;
        pc_load_o       <= seq_req_i.irq_high ? `RAS_VEC_HIGH : `RAS_VEC_LOW;
      end
      else if (!push_any && seq_req_i.ret_pop)
      begin
        pc_load_valid_o <= 1'b1;
        pc_load_o       <= (ptr == `RAS_PTR_RST) ? `RAS_VEC_RESET : top;
      end
    end
  end

  // ----------------------------------------
  // Program fetch guard
  // ----------------------------------------
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      fetch_word_o <= 16'h0000;
    end
    else
    begin
      fetch_word_o <= ({1'b0, fetch_addr_i} >= IMPL_LIM) ? 16'h0000 : fetch_word_i;
    end
  end

  // ----------------------------------------
  // Register access
  // ----------------------------------------
  assign ptr_img = '{stack_full_flag: full_flag, stack_underflow_flag: under_flag, zero: 1'b0, ptr: ptr};
  assign sw_ptr_wr = wr_stb && paddr_i == `RAS_OFF_PTR;
  assign sw_lane   = {wr_stb && paddr_i == `RAS_OFF_TOP_U,
                      wr_stb && paddr_i == `RAS_OFF_TOP_H,
                      wr_stb && paddr_i == `RAS_OFF_TOP_L};

  always_comb
  begin
    hit     = 1'b1;
    rd_data = 32'h00000000;
    case (paddr_i)
      `RAS_OFF_PTR:   rd_data = {24'h000000, ptr_img};
      `RAS_OFF_TOP_U: rd_data = {27'h0000000, top[20:16]};
      `RAS_OFF_TOP_H: rd_data = {24'h000000, top[15:8]};
      `RAS_OFF_TOP_L: rd_data = {24'h000000, top[7:0]};
      default:        hit     = 1'b0;
    endcase
  end

  ras_apb_slave u_apb (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .psel_i    (psel_i),
    .penable_i (penable_i),
    .pwrite_i  (pwrite_i),
    .rd_data_i (rd_data),
    .hit_i     (hit),
    .pready_o  (pready_o),
    .pslverr_o (pslverr_o),
    .prdata_o  (prdata_o),
    .wr_stb_o  (wr_stb)
  );

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  sequence s_push_at(logic [4:0] p);
    !core_reset_i && push_any && ptr == p;
  endsequence
  sequence s_pop_empty;
    !core_reset_i && !push_any && pop_any && ptr == `RAS_PTR_RST;
  endsequence

  a_push_ptr_step: assert property (s_push_at(ptr) and (ptr < `RAS_PTR_PREFULL) |=> ptr == $past(ptr) + 5'h01)
    else $error("push did not advance pointer");
  a_push_stores_pc: assert property (s_push_at(ptr) and (ptr < `RAS_PTR_PREFULL) |=> top == $past(seq_req_i.pc))
    else $error("pushed PC not at top");
  a_pop_loads_top: assert property (!core_reset_i && !push_any && seq_req_i.ret_pop && ptr != 5'h00
                                    |=> pc_load_valid_o && pc_load_o == $past(top) && ptr == $past(ptr) - 5'h01)
    else $error("pop loaded wrong PC");
  a_under_zero: assert property (s_pop_empty |=> ptr == 5'h00 && under_flag)
    else $error("underflow handling wrong");
  a_ovf_reset: assert property (s_push_at(`RAS_PTR_PREFULL) and fault_reset_enable_i
                                |=> stack_reset_o && full_flag && ptr == 5'h00 ##1 !stack_reset_o)
    else $error("overflow reset sequence wrong");
  a_full_holds: assert property (s_push_at(`RAS_PTR_LAST) |=> ptr == 5'h1f && full_flag && $stable(ent_q[31]))
    else $error("pointer or entry moved past full");
  a_flags_sticky: assert property (full_flag && !(sw_ptr_wr && !pwdata_i[7]) |=> full_flag)
    else $error("full flag lost without clear");
  a_empty_reads: assert property (ptr == 5'h00 && psel_i && !penable_i && !pwrite_i && paddr_i == `RAS_OFF_TOP_L
                                  |=> pready_o && prdata_o == 32'h00000000)
    else $error("top read at empty not zero");
  a_irq_vector: assert property (!core_reset_i && seq_req_i.irq_push && seq_req_i.irq_high
                                 |=> pc_load_valid_o && pc_load_o == 21'h000008)
    else $error("high vector wrong");
  a_fetch_void: assert property ({1'b0, fetch_addr_i} >= IMPL_LIM |=> fetch_word_o == 16'h0000)
    else $error("fetch beyond memory not zero");

  // Software pointer writes only land when no stack operation competes in the cycle
  sequence s_quiet_sw;
    !core_reset_i && !push_any && !pop_any;
  endsequence

  a_wake_push: assert property (!core_reset_i && wake_ok && ptr < `RAS_PTR_PREFULL
                                |=> ptr == $past(ptr) + 5'h01 && top == $past(seq_req_i.pc))
    else $error("wake-up did not push PC");
  a_pop_discard: assert property (!core_reset_i && !push_any && seq_req_i.pop_inst && !seq_req_i.ret_pop
                                  && ptr != 5'h00 |=> ptr == $past(ptr) - 5'h01 && !pc_load_valid_o)
    else $error("pop instruction did not only discard");
  a_under_sticky: assert property (under_flag && !(sw_ptr_wr && !pwdata_i[`RAS_UNDER_BIT])
                                   |=> under_flag)
    else $error("underflow flag lost without clear");
  a_core_clear: assert property (core_reset_i
                                 |=> ptr == 5'h00 && pc_load_o == 21'h000000)
    else $error("core reset did not clear pointer");
  a_top_write: assert property (s_quiet_sw and (ptr != 5'h00 && sw_lane[0])
                                |=> top[7:0] == $past(pwdata_i[7:0]))
    else $error("top low byte write lost");
  a_sw_ptr_write: assert property (s_quiet_sw and sw_ptr_wr
                                   |=> ptr == $past(pwdata_i[4:0]))
    else $error("software pointer write lost");
  a_low_vector: assert property (!core_reset_i && seq_req_i.irq_push && !seq_req_i.irq_high
                                 |=> pc_load_valid_o && pc_load_o == `RAS_VEC_LOW)
    else $error("low vector wrong");
endmodule : ras_top

/* File: verification/ras_seq_model.sv */
// Sequencer stand-in: turns bench opcodes into one-cycle stack requests.
// Assumes opcodes change just after a rising edge of ref_clk_i.
`timescale 1ns/10ps
module ras_seq_model (
  input  wire logic            ref_clk_i,
  input  wire logic            rst_i,
  input  wire logic [2:0]      op_i,
  input  wire logic [20:0]     pc_i,
  input  wire logic            gie_i,
  output ras_pkg::ras_seq_req_t seq_req_o
);
  // ----------------------------------------
  // Request register
  // ----------------------------------------
  // Registered so every pulse lasts exactly one cycle
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      seq_req_o <= '0;
    end
    else
    begin
      seq_req_o           <= '0;
      seq_req_o.pc        <= pc_i;
      seq_req_o.call_push <= (op_i == 3'h1);
      seq_req_o.irq_push  <= (op_i == 3'h2) || (op_i == 3'h3);
      seq_req_o.irq_high  <= (op_i != 3'h3);
      seq_req_o.wake_irq  <= (op_i == 3'h4);
      seq_req_o.gie_high  <= gie_i;  // Low whenever software touches the top
      seq_req_o.ret_pop   <= (op_i == 3'h5);
      seq_req_o.push_inst <= (op_i == 3'h6);
      seq_req_o.pop_inst  <= (op_i == 3'h7);
    end
  end
endmodule : ras_seq_model

/* File: verification/ras_top_bench.sv */
// Bench for ras_top: sequencer model, APB master, queued expectations.
// Assumes a zero-wait APB slave and one-cycle sequencer pulses.
`timescale 1ns/10ps
`include "ras_params.svh"
module ras_top_bench;
  logic                  ref_clk_i = 1'b0;
  logic                  rst_i = 1'b1;
  logic                  core_reset_i = 1'b0;
  logic                  fault_reset_enable_i = 1'b0;
  ras_pkg::ras_seq_req_t seq_req_i;
  logic [20:0]           fetch_addr_i = 21'h0;
  logic [15:0]           fetch_word_i = 16'h0;
  logic                  psel_i = 1'b0;
  logic                  penable_i = 1'b0;
  logic                  pwrite_i = 1'b0;
  logic [7:0]            paddr_i = 8'h0;
  logic [31:0]           pwdata_i = 32'h0;
  logic [31:0]           prdata_o;
  logic                  pready_o;
  logic                  pslverr_o;
  logic                  pc_load_valid_o;
  logic [20:0]           pc_load_o;
  logic                  stack_reset_o;
  logic [15:0]           fetch_word_o;
  logic [2:0]            op = 3'h0;
  logic [20:0]           pc = 21'h0;
  logic                  gie = 1'b0;
  logic                  err;
  logic [31:0]           exp_rd [$];
  logic [31:0]           exp_pc [$];
  logic [20:0]           pv [5];
  logic [20:0]           p;
  int                    bad_count = 0;
  int                    samples_checked = 0;
  int                    resets_seen = 0;
  int                    i;
  logic [2:0]            ops [5] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h6};
  logic [20:0]           vec [5] = '{21'h0, `RAS_VEC_HIGH, `RAS_VEC_LOW, `RAS_VEC_HIGH, 21'h0};

  always #5 ref_clk_i = ~ref_clk_i;

  ras_top #(.DEPTH(31), .IMPL_BYTES(32768)) uut (
    .ref_clk_i, .rst_i, .core_reset_i, .fault_reset_enable_i, .seq_req_i, .fetch_addr_i,
    .fetch_word_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o,
    .pslverr_o, .pc_load_valid_o, .pc_load_o, .stack_reset_o, .fetch_word_o
  );

  ras_seq_model mdl (
    .ref_clk_i, .rst_i, .op_i(op), .pc_i(pc), .gie_i(gie), .seq_req_o(seq_req_i)
  );

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic conclude();
    $display("Compares %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : conclude

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge ref_clk_i);
    penable_i <= 1'b1;
    // No timeout here: only pready_o or the watchdog ends the wait for the answer
    do
    begin
      @(posedge ref_clk_i);
    end
    while (pready_o !== 1'b1);
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_rd.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  // Model registers the opcode, so the stack acts two edges later
  task automatic seq(input logic [2:0] o, input logic [20:0] v);
    @(posedge ref_clk_i);
    op <= o;
    pc <= v;
    @(posedge ref_clk_i);
    op <= 3'h0;
    repeat (2) @(posedge ref_clk_i);
  endtask : seq

  function automatic logic [20:0] rp();
    return 21'($urandom) & 21'h1ffffe;
  endfunction : rp

  // ----------------------------------------
  // Monitor and watchdog
  // ----------------------------------------
  always @(posedge ref_clk_i)
  begin
    if (psel_i && penable_i && pready_o && !pwrite_i)
      chk(prdata_o, exp_rd.pop_front());
    if (pc_load_valid_o)
      chk({11'h0, pc_load_o}, exp_pc.pop_front());
    if (stack_reset_o)
      resets_seen++;
  end

  initial
  begin
    repeat (6000) @(posedge ref_clk_i);
    bad_count++;
    conclude();
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial
  begin
    void'($urandom(11));
    repeat (12) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    rd(`RAS_OFF_PTR, 32'h0);
    rd(`RAS_OFF_TOP_L, 32'h0);
    rd(8'h10, 32'h0);
    chk({31'h0, err}, 32'h1);
    p = rp();
    seq(3'h1, p);
    rd(`RAS_OFF_PTR, 32'h1);
    rd(`RAS_OFF_TOP_U, {27'h0, p[20:16]});
    rd(`RAS_OFF_TOP_H, {24'h0, p[15:8]});
    wr(`RAS_OFF_TOP_L, 32'h5a);
    exp_pc.push_back({11'h0, p[20:8], 8'h5a});
    seq(3'h5, 21'h0);
    rd(`RAS_OFF_PTR, 32'h0);
    // Every push kind, vectors where interrupts are taken
    gie <= 1'b1;
    for (i = 0; i < 5; i++)
    begin
      pv[i] = rp();
      if (vec[i] !== 21'h0)
        exp_pc.push_back({11'h0, vec[i]});
      seq(ops[i], pv[i]);
    end
    gie <= 1'b0;
    seq(3'h4, rp());
    rd(`RAS_OFF_PTR, 32'h5);
    seq(3'h7, 21'h0);
    rd(`RAS_OFF_PTR, 32'h4);
    for (i = 3; i >= 0; i--)
    begin
      exp_pc.push_back({11'h0, pv[i]});
      seq(3'h5, 21'h0);
    end
    exp_pc.push_back(32'h0);
    seq(3'h5, 21'h0);
    rd(`RAS_OFF_PTR, 32'h40);
    // Leave a pushed entry so the core reset has a pointer to clear
    seq(3'h1, rp());
    @(posedge ref_clk_i);
    core_reset_i <= 1'b1;
    @(posedge ref_clk_i);
    core_reset_i <= 1'b0;
    rd(`RAS_OFF_PTR, 32'h40);
    wr(`RAS_OFF_PTR, 32'h23);
    rd(`RAS_OFF_PTR, 32'h3);
    wr(`RAS_OFF_PTR, 32'h0);
    for (i = 0; i < 31; i++)
    begin
      p = rp();
      seq(3'h1, p);
    end
    rd(`RAS_OFF_PTR, 32'h9f);
    seq(3'h1, p ^ 21'h000100);
    rd(`RAS_OFF_PTR, 32'h9f);
    rd(`RAS_OFF_TOP_H, {24'h0, p[15:8]});
    // Overflow with fault reset: no return load, only the reset request
    wr(`RAS_OFF_PTR, {27'h0, `RAS_PTR_PREFULL});
    fault_reset_enable_i <= 1'b1;
    i = resets_seen;
    p = rp();
    seq(3'h1, p);
    rd(`RAS_OFF_PTR, 32'h80);
    chk(32'(resets_seen - i), 32'h1);
    wr(`RAS_OFF_PTR, {27'h0, `RAS_PTR_LAST});
    p = p + `RAS_PC_STEP;
    rd(`RAS_OFF_TOP_L, {24'h0, p[7:0]});
    rd(`RAS_OFF_TOP_U, {27'h0, p[20:16]});
    for (i = 0; i < 6; i++)
    begin
      @(posedge ref_clk_i);
      fetch_addr_i <= (i < 3) ? 21'($urandom_range(32'h7fff)) : 21'($urandom_range(32'h1fffff, 32'h8000));
      fetch_word_i <= 16'($urandom);
      @(posedge ref_clk_i);
      #1;
      chk({16'h0, fetch_word_o}, (fetch_addr_i < 21'h8000) ? {16'h0, fetch_word_i} : 32'h0);
    end
    chk(32'(exp_pc.size() + exp_rd.size()), 32'h0);
    conclude();
  end
endmodule : ras_top_bench
